//--- design/subrate_ds0_port_mux.sv
// Subrate DS0 port multiplexer: ten terminal ports into WAN subrate slots.
// Assumes AXI4-Lite from the same clock, pins from outside the clock domain.
`default_nettype none
`include "subrate_consts.svh"
module subrate_ds0_port_mux
  import subrate_pkg::*;
#(
  parameter int unsigned CTS_D30_CYC  = `CTS_D30_MS * `CYC_PER_MS,
  parameter int unsigned CTS_D60_CYC  = `CTS_D60_MS * `CYC_PER_MS,
  parameter int unsigned CTS_D100_CYC = `CTS_D100_MS * `CYC_PER_MS,
  parameter bit          LOW_DELAY    = 1'b0
) (
  // Clock, reset, enable
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // AXI4-Lite slave
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [7:0]         awaddr,
  input  wire logic               wvalid,
  output logic                    wready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  output logic                    bvalid,
  input  wire logic               bready,
  output logic [1:0]              bresp,
  input  wire logic               arvalid,
  output logic                    arready,
  input  wire logic [7:0]         araddr,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  // Terminal pins
  input  wire logic [`NPORT-1:0]  term_txd,
  input  wire logic [`NPORT-1:0]  term_rts,
  output logic [`NPORT-1:0]       term_rxd,
  output logic [`NPORT-1:0]       term_cts,
  output logic [`NPORT-1:0]       carrier_detect_lead,
  // Far end signalling
  input  wire logic [`NPORT-1:0]  remote_rts,
  output logic [`NPORT-1:0]       far_cd,
  input  wire logic [7:0]         wan_up,
  // WAN subrate slot stream
  input  wire logic               slot_stb,
  input  wire logic [2:0]         slot_wan,
  input  wire logic [4:0]         slot_ts,
  input  wire logic [4:0]         slot_sub,
  input  wire logic               wan_rx_bit,
  output logic                    wan_tx_bit
);
  state_t       s, next_s;
  slot_check_if ck();
  logic [3:0]   idx;
  logic [31:0]  old, wd;
  logic         commit, cfg_w, e1, sig;
  logic         ts_bad, opt_bad, rate_bad, reuse, ovl, own_any;
  logic [11:0]  bw_all, bw_oth;
  logic [2:0]   code;
  logic [7:0]   adp [3];

  slot_mapper u_map (.ck(ck));

  // Register window decode
  function automatic logic port_hit(input logic [7:0] a, input logic [7:0] base);
    port_hit = a[7:6] == base[7:6] && a[5:2] < 4'(`NPORT) && a[1:0] == 2'h0;
  endfunction

  // CTS delay in cycles per mode
  function automatic logic [23:0] cts_delay(input logic [3:0] m);
    unique case (m)
      CT_L30, CT_RL3:  cts_delay = 24'(CTS_D30_CYC);
      CT_L60, CT_RL6:  cts_delay = 24'(CTS_D60_CYC);
      CT_L100, CT_RL10: cts_delay = 24'(CTS_D100_CYC);
      default: cts_delay = 24'h00_0000;
    endcase
  endfunction

  // Candidate word with byte strobes applied
  assign idx = s.aw_addr[5:2];
  assign old = (idx >= 4'(`NPORT)) ? 32'h0000_0000 :
    port_hit(s.aw_addr, `OFS_CTL) ? 32'(s.ctl[idx]) : s.cfg[idx]; // Own word per window
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wd[8*b+7:8*b] = s.w_strb[b] ? s.w_data[8*b+7:8*b] : old[8*b+7:8*b];
  end
  assign ck.frame = wd[`F_FRM];
  assign ck.rate = wd[`F_RATE];
  assign ck.start = (wd[`F_FRM] == FR_A || wd[`F_FRM] == FR_NLINK) ?
    5'h01 : wd[`F_SUB];
  assign commit = s.aw_full && s.w_full && !s.bvalid;
  assign cfg_w = port_hit(s.aw_addr, `OFS_CFG);

  // Slot range by link type and signalling
  assign e1 = s.card[wd[3:1]];
  assign sig = s.card[8 + 32'(wd[3:1])];
  assign ts_bad = wd[`F_TS] == 5'h00 ||
    (e1 ? (wd[`F_TS] > `E1_MAX_TS || (sig && wd[`F_TS] == `E1_SIG_TS))
        : wd[`F_TS] > `T1_MAX_TS);

  // Option set: variant framings and character format
  assign opt_bad = (LOW_DELAY && (wd[`F_FRM] == FR_X50 || wd[`F_FRM] == FR_NLINK))
    || wd[`F_INTERFACE_PROTOCOL_SETTING] > IF_V14 || wd[`F_PAR] > `PAR_MAX;

  // Rate legality for the interface
  assign rate_bad = ck.bad_rate || (wd[`F_INTERFACE_PROTOCOL_SETTING] == IF_SYNC &&
    (wd[`F_RATE] == RT_0K3 || wd[`F_RATE] == RT_1K2 ||
     (wd[`F_RATE] == RT_14K4 && wd[`F_FRM] != FR_ADPCM &&
      wd[`F_FRM] != FR_HLINK)));

  // First failing check wins
  always_comb begin
    if (ts_bad) code = ER_TS;
    else if (reuse) code = ER_REUSE;
    else if (opt_bad) code = ER_OPT;
    else if (rate_bad) code = ER_RATE;
    else if (ck.bad_span) code = ER_SPAN;
    else if (ovl) code = ER_OVL;
    else if (wd[`F_ACT] && wd[`F_INTERFACE_PROTOCOL_SETTING] == IF_SYNC &&
             bw_oth + rate_bw(wd[`F_RATE]) > `BW_LIMIT) code = ER_BW;
    else code = ER_NONE;
  end

  // Cross-port checks and card totals
  always_comb begin
    reuse = 1'b0;
    ovl = 1'b0;
    bw_all = 12'h000;
    bw_oth = 12'h000;
    for (int r = 0; r < 3; r++) adp[r] = 8'h00;
    for (int i = 0; i < `NPORT; i++) begin
      if (s.cfg[i][`F_ACT]) begin
        if (s.cfg[i][`F_INTERFACE_PROTOCOL_SETTING] == IF_SYNC) begin
          bw_all = bw_all + rate_bw(s.cfg[i][`F_RATE]);
          if (4'(i) != idx) bw_oth = bw_oth + rate_bw(s.cfg[i][`F_RATE]);
        end
        if (s.cfg[i][`F_FRM] == FR_ADPCM && s.ctl[i][`F_ADP] != 2'h0)
          adp[s.ctl[i][`F_ADP] - 2'h1] = adp[s.ctl[i][`F_ADP] - 2'h1] + `ADP_KBPS;
        if (4'(i) != idx && s.cfg[i][`F_TS] == wd[`F_TS]) begin
          if (s.cfg[i][`F_WAN] != wd[`F_WAN]) reuse = 1'b1;
          else if ((s.mask[i] & ck.mask) != 20'h0_0000) ovl = 1'b1;
        end
      end
    end
  end

  // Next state of the whole block
  always_comb begin
    next_s = s;
    own_any = 1'b0;
    // Pin synchronisers
    next_s.rts_m = term_rts;
    next_s.rts_s = s.rts_m;
    next_s.txd_m = term_txd;
    next_s.txd_s = s.txd_m;
    // Write address and data capture
    if (awvalid && !s.aw_full) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && !s.w_full) begin
      next_s.w_full = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) next_s.bvalid = 1'b0;
    // Write commit
    if (commit) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `AXI_OKAY;
      if (cfg_w) begin
        next_s.err[idx] = code;
        next_s.lerr = code;
        if (code == ER_NONE) begin
          next_s.cfg[idx] = wd;
          if (wd[`F_FRM] == FR_A || wd[`F_FRM] == FR_NLINK)
            next_s.cfg[idx][`F_SUB] = 5'h01;
          if (wd[`F_FRM] == FR_ADPCM || wd[`F_FRM] == FR_HLINK)
            next_s.cfg[idx][`F_SUB] = 5'h00;
          next_s.mask[idx] = ck.mask;
        end else begin
          next_s.bresp = `AXI_SLVERR;
        end
      end else if (port_hit(s.aw_addr, `OFS_CTL)) begin
        next_s.ctl[idx] = wd[8:0];
      end else if (s.aw_addr == `OFS_CARD) begin
        if (s.w_strb[0]) next_s.card[7:0] = s.w_data[7:0];
        if (s.w_strb[1]) next_s.card[15:8] = s.w_data[15:8];
      end else begin
        next_s.bresp = `AXI_SLVERR;
      end
    end
    // Read path
    if (s.rvalid && rready) next_s.rvalid = 1'b0;
    if (arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `AXI_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (port_hit(araddr, `OFS_CFG)) begin
        next_s.rdata = s.cfg[araddr[5:2]];
        if (s.cfg[araddr[5:2]][`F_INTERFACE_PROTOCOL_SETTING] == IF_SYNC)
          next_s.rdata[`F_CHAR] = 6'h00;
      end else if (port_hit(araddr, `OFS_CTL)) begin
        next_s.rdata[8:0] = s.ctl[araddr[5:2]];
      end else if (port_hit(araddr, `OFS_STAT)) begin
        next_s.rdata[6:0] = {s.err[araddr[5:2]], s.far_cd[araddr[5:2]],
          s.cd[araddr[5:2]], s.cts[araddr[5:2]], s.cfg[araddr[5:2]][`F_ACT]};
      end else if (araddr == `OFS_CARD) begin
        next_s.rdata[15:0] = s.card;
      end else if (araddr == `OFS_BW) begin
        next_s.rdata[11:0] = bw_all;
      end else if (araddr == `OFS_LERR) begin
        next_s.rdata[2:0] = s.lerr;
      end else if (araddr == `OFS_ADP) begin
        next_s.rdata[23:0] = {adp[2], adp[1], adp[0]};
      end else begin
        next_s.rresp = `AXI_SLVERR;
      end
    end
    // Control leads per port
    for (int i = 0; i < `NPORT; i++) begin
      if (!s.rts_s[i]) next_s.cts_cnt[i] = 24'h00_0000;
      else if (s.cts_cnt[i] < cts_delay(s.ctl[i][`F_CTS]))
        next_s.cts_cnt[i] = s.cts_cnt[i] + 24'h00_0001;
      next_s.cts[i] = s.cfg[i][`F_ACT] && (s.ctl[i][`F_CTS] == CT_PERM ||
        (s.ctl[i][`F_CTS] != CT_OFF && s.ctl[i][`F_CTS] < 4'(`NPORT) && s.rts_s[i] &&
         s.cts_cnt[i] >= cts_delay(s.ctl[i][`F_CTS])));
      next_s.cd[i] = s.cfg[i][`F_ACT] && wan_up[s.cfg[i][`F_WAN]] &&
        (!s.ctl[i][`F_CDF] || remote_rts[i]);
      next_s.far_cd[i] = s.cfg[i][`F_ACT] && s.rts_s[i] &&
        s.ctl[i][`F_CTS] >= CT_RL0 && s.ctl[i][`F_CTS] <= CT_RL10;
      if (!s.cfg[i][`F_ACT]) next_s.rxd[i] = 1'b1;
    end
    // Subrate slot exchange; standby ports own nothing
    if (slot_stb) begin
      next_s.tx_bit = 1'b1;
      for (int i = 0; i < `NPORT; i++) begin
        if (s.cfg[i][`F_ACT] && s.cfg[i][`F_WAN] == slot_wan &&
            s.cfg[i][`F_TS] == slot_ts && slot_sub != 5'h00 &&
            slot_sub <= 5'(`NSUB) && s.mask[i][slot_sub - 5'h01]) begin
          own_any = 1'b1;
          if (!s.txd_s[i]) next_s.tx_bit = 1'b0;
          next_s.rxd[i] = wan_rx_bit;
        end
      end
    end
  end

  // State register with enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.cfg <= {`NPORT{`RST_CFG}};
      s.mask <= {`NPORT{`RST_MASK}};
      s.rxd <= '1;
      s.tx_bit <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Outputs
  assign awready = !s.aw_full;
  assign wready = !s.w_full;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign term_rxd = s.rxd;
  assign term_cts = s.cts;
  assign carrier_detect_lead = s.cd;
  assign far_cd = s.far_cd;
  assign wan_tx_bit = s.tx_bit;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_cfg_commit;
    ce && commit && cfg_w;
  endsequence
  sequence s_reject;
    s_cfg_commit ##0 code != ER_NONE;
  endsequence

  a_reject_keeps: assert property (s_reject |=> s.cfg == $past(s.cfg) &&
    s.mask == $past(s.mask) && bvalid && bresp == `AXI_SLVERR)
    else $error("rejected write changed state");
  a_span_error: assert property (s_cfg_commit ##0 (ck.bad_span && code > ER_RATE)
    |=> s.lerr == ER_SPAN) else $error("span error not reported");
  a_overlap_err: assert property (s_cfg_commit ##0 (ovl && code > ER_SPAN)
    |=> s.lerr == ER_OVL) else $error("overlap not reported");
  a_bw_limit: assert property (bw_all <= `BW_LIMIT)
    else $error("sync bandwidth above limit");
  a_ts_range: assert property (s_cfg_commit ##0 code == ER_NONE |-> wd[`F_TS] != 5'h00
    && wd[`F_TS] <= (e1 ? `E1_MAX_TS : `T1_MAX_TS)) else $error("slot out of range");
  a_slot_reuse: assert property (!(s.cfg[1][`F_ACT] && s.cfg[2][`F_ACT] &&
    s.cfg[1][`F_TS] == s.cfg[2][`F_TS] && s.cfg[1][`F_WAN] != s.cfg[2][`F_WAN]))
    else $error("slot number on two links");
  a_sync_rate: assert property (s.cfg[4][`F_INTERFACE_PROTOCOL_SETTING] == IF_SYNC |->
    s.cfg[4][`F_RATE] > RT_1K2) else $error("illegal sync rate stored");
  a_cd_low: assert property (ce && (!s.cfg[1][`F_ACT] || !wan_up[s.cfg[1][`F_WAN]])
    |=> !carrier_detect_lead[1]) else $error("carrier detect not low");
  a_cts_standby: assert property (ce && !s.cfg[0][`F_ACT] |=> !term_cts[0])
    else $error("cts high in standby");
  a_cts_prompt: assert property (ce && s.cfg[8][`F_ACT] && s.rts_s[8] &&
    (s.ctl[8][`F_CTS] == CT_L0 || s.ctl[8][`F_CTS] == CT_RL0) |=> term_cts[8])
    else $error("immediate cts late");
  a_idle_fill: assert property (ce && slot_stb && !own_any |=> wan_tx_bit)
    else $error("unowned slot not idle");
  a_dsa_index: assert property (s.cfg[0][`F_FRM] == FR_A |->
    s.cfg[0][`F_SUB] == 5'h01) else $error("ds0a index not one");
  a_x50_stride: assert property (ck.frame == FR_X50 && ck.rate == RT_4K8 &&
    ck.start == 5'h03 |-> ck.mask == 20'h0_1004) else $error("x50 interleave wrong");
endmodule
`default_nettype wire

//--- design/subrate_consts.svh
// Constants of the subrate port multiplexer: offsets, fields, timing.
// Assumes a 100 MHz sys_clk; included by the package and by the top.
// Operation
// - Carrier detect high or remote RTS, else low
// - CTS low in standby, else per mode
// - Slot 1-24 T1, 1-31 E1, signalled 16 excluded
// - Slot number never used on two links
// - Framing gives one, five, ten, twenty slots
// - Index 1 for DS0A, none for ADPCM
// - 19.2 kbps and above takes contiguous 9.6 slots
// - Span past last slot gives index error
// - Colliding span gives overlap error
// - X.50 slot count set by rate
// - X.50 circuits interleave at rate stride
// - Synchronous total never above 115.2 kbps
// - Sync refuses 0.3, 1.2, most 14.4
// - Character format not applicable when sync
// - Async data bits 8, 7, 6, 5
// - Async stop bits one or two
// - Parity none, odd, even, space, mark
// - Async and V.14 carried both directions
// - ADPCM framing takes 24 kbps of resource
// - Twenty-slot slots shareable with other cards
// - Low-delay variant limits framings, no delay option
// - CTS delayed after RTS; remote modes drive far CD
`ifndef SUBRATE_CONSTS_SVH
`define SUBRATE_CONSTS_SVH

`define NPORT 10
`define NSUB 20
`define OFS_CFG 8'h00
`define OFS_CTL 8'h40
`define OFS_STAT 8'h80
`define OFS_CARD 8'hC0
`define OFS_BW 8'hC4
`define OFS_LERR 8'hC8
`define OFS_ADP 8'hCC
`define F_ACT 0
`define F_WAN 3:1
`define F_TS 8:4
`define F_FRM 11:9
`define F_RATE 15:12
`define F_SUB 20:16
`define F_INTERFACE_PROTOCOL_SETTING 22:21
`define F_CHAR 28:23
`define F_PAR 28:26
`define F_CTS 3:0
`define F_ADP 5:4
`define F_CDF 8
`define F_E1 7:0
`define F_SIG 15:8
`define RST_CFG 32'h0001_0010
`define RST_MASK 20'h0_0001
`define T1_MAX_TS 5'h18
`define E1_MAX_TS 5'h1F
`define E1_SIG_TS 5'h10
`define BW_LIMIT 12'h480
`define ADP_KBPS 8'h18
`define PAR_MAX 3'h4
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define CLK_MHZ 100
`define CYC_PER_MS (`CLK_MHZ * 1000)
`define CTS_D30_MS 30
`define CTS_D60_MS 60
`define CTS_D100_MS 100

`endif

//--- design/subrate_pkg.sv
// Types of the subrate port multiplexer.
// Assumes subrate_consts.svh beside it.
`default_nettype none
package subrate_pkg;
`include "subrate_consts.svh"

  typedef enum logic [2:0] {FR_A = 3'h0, FR_B5 = 3'h1, FR_B10 = 3'h2, FR_B20 = 3'h3,
    FR_X50 = 3'h4, FR_ADPCM = 3'h5, FR_HLINK = 3'h6, FR_NLINK = 3'h7} frame_t;
  typedef enum logic [3:0] {RT_0K3 = 4'h0, RT_1K2 = 4'h1, RT_2K4 = 4'h2, RT_4K8 = 4'h3,
    RT_9K6 = 4'h4, RT_14K4 = 4'h5, RT_19K2 = 4'h6, RT_28K8 = 4'h7,
    RT_38K4 = 4'h8} rate_t;
  typedef enum logic [1:0] {IF_ASYN = 2'h0, IF_SYNC = 2'h1, IF_V14 = 2'h2} interface_protocol_setting_t;
  typedef enum logic [3:0] {CT_PERM = 4'h0, CT_L0 = 4'h1, CT_L30 = 4'h2, CT_L60 = 4'h3,
    CT_L100 = 4'h4, CT_RL0 = 4'h5, CT_RL3 = 4'h6, CT_RL6 = 4'h7, CT_RL10 = 4'h8,
    CT_OFF = 4'h9} cts_t;
  typedef enum logic [2:0] {ER_NONE = 3'h0, ER_TS = 3'h1, ER_REUSE = 3'h2, ER_OPT = 3'h3,
    ER_RATE = 3'h4, ER_SPAN = 3'h5, ER_OVL = 3'h6, ER_BW = 3'h7} err_t;

  // Rate in units of 0.1 kbps
  function automatic logic [11:0] rate_bw(input logic [3:0] r);
    unique case (r)
      RT_0K3:  rate_bw = 12'h003;
      RT_1K2:  rate_bw = 12'h00C;
      RT_2K4:  rate_bw = 12'h018;
      RT_4K8:  rate_bw = 12'h030;
      RT_9K6:  rate_bw = 12'h060;
      RT_14K4: rate_bw = 12'h090;
      RT_19K2: rate_bw = 12'h0C0;
      RT_28K8: rate_bw = 12'h120;
      RT_38K4: rate_bw = 12'h180;
      default: rate_bw = 12'h000;
    endcase
  endfunction

  typedef struct packed {
    logic [`NPORT-1:0][31:0] cfg;
    logic [`NPORT-1:0][8:0]  ctl;
    logic [`NPORT-1:0][19:0] mask;
    logic [`NPORT-1:0][2:0]  err;
    logic [`NPORT-1:0][23:0] cts_cnt;
    logic [15:0]             card;
    logic [2:0]              lerr;
    logic [`NPORT-1:0]       rts_m, rts_s, txd_m, txd_s;
    logic [`NPORT-1:0]       cd, cts, far_cd, rxd;
    logic                    tx_bit;
    logic                    aw_full, w_full, bvalid, rvalid;
    logic [7:0]              aw_addr;
    logic [31:0]             w_data, rdata;
    logic [3:0]              w_strb;
    logic [1:0]              bresp, rresp;
  } state_t;
endpackage
`default_nettype wire

//--- design/slot_check_if.sv
// Carrier between the top and its subrate slot mapper.
// Assumes one requester and one mapper.
`default_nettype none
interface slot_check_if;
  logic [2:0]  frame;
  logic [3:0]  rate;
  logic [4:0]  start;
  logic [19:0] mask;
  logic        bad_span;
  logic        bad_rate;
  modport req (output frame, rate, start, input mask, bad_span, bad_rate);
  modport chk (input frame, rate, start, output mask, bad_span, bad_rate);
endinterface
`default_nettype wire

//--- design/slot_mapper.sv
// Subrate slot mapper: occupancy mask of one candidate circuit.
// Assumes framing and rate codes of subrate_pkg; purely combinational.
`default_nettype none
`include "subrate_consts.svh"
module slot_mapper
  import subrate_pkg::*;
(
  // Request and answer
  slot_check_if.chk ck
);
  logic [5:0] slots;
  logic [5:0] width;
  logic       sub;
  logic       x50;
  wire [19:0] bits;

  // Slot count and span width from framing and rate
  always_comb begin
    slots = 6'h00;
    width = 6'h01;
    sub = 1'b1;
    x50 = 1'b0;
    ck.bad_rate = (ck.rate > RT_38K4);
    unique case (frame_t'(ck.frame))
      FR_A, FR_NLINK: slots = 6'h01;
      FR_B5:  slots = 6'h05;
      FR_B10: slots = 6'h0A;
      FR_B20: slots = 6'h14;
      FR_X50: begin
        x50 = 1'b1;
        unique case (rate_t'(ck.rate))
          RT_2K4: slots = 6'h14;
          RT_4K8: slots = 6'h0A;
          RT_9K6: slots = 6'h05;
          default: ck.bad_rate = 1'b1;
        endcase
      end
      FR_ADPCM, FR_HLINK: sub = 1'b0;
    endcase
    // Wide rates fill contiguous 9.6 kbps slots
    if (sub && !x50 && slots != 6'h01) begin
      unique case (rate_t'(ck.rate))
        RT_19K2: width = 6'h02;
        RT_28K8: width = 6'h03;
        RT_38K4: width = 6'h04;
        default: width = 6'h01;
      endcase
    end
  end

  // Index zero or span past the frame end
  assign ck.bad_span = sub && (ck.start == 5'h00 ||
    ({1'b0, ck.start} + width - 6'h01) > slots);

  // One decision per subrate position
  for (genvar k = 0; k < `NSUB; k++) begin : g_pos
    logic [5:0] d;
    assign d = 6'(k + 1) - {1'b0, ck.start};
    assign bits[k] = sub && !ck.bad_rate && 6'(k + 1) >= {1'b0, ck.start} &&
      (x50 ? (d == 6'h00 || d == slots || d == 6'(2 * slots) ||
              d == 6'(3 * slots))
           : d < width);
  end
  assign ck.mask = bits;
endmodule
`default_nettype wire

//--- dv/term_dte.sv
// Terminal model for all ten ports: raises RTS on request, sends under CTS.
// Assumes the bench clock; the bench sets the requests and transmit levels.
`default_nettype none
module term_dte #(
  parameter int N = 10
) (
  // Clock
  input  wire logic         sys_clk,
  // Bench requests
  input  wire logic [N-1:0] rts_req,
  input  wire logic [N-1:0] tx_bit,
  // Port pins
  input  wire logic [N-1:0] term_cts,
  output logic      [N-1:0] term_rts,
  output logic      [N-1:0] term_txd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles at mark until the port grants clear to send
  always @(posedge sys_clk) begin
    term_rts <= rts_req;
    term_txd <= tx_bit | ~(rts_req & term_cts);
  end
  initial begin
    term_rts = '0;
    term_txd = '1;
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the subrate port multiplexer.
// Assumes the design package, its constants header and the terminal model.
`default_nettype none
`include "subrate_consts.svh"
`define CHK(g, e, m) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("wrong value at %0t: %s", $time, m); \
  end \
end
module tb_top
  import subrate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = `AXI_OKAY;
  localparam logic [1:0] ER = `AXI_SLVERR;
  logic              sys_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0, slot_stb = 1'b0, wan_rx_bit = 1'b1;
  logic [7:0]        awaddr = '0, araddr = '0, wan_up = 8'hFF;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        wstrb = 4'hF;
  logic [2:0]        slot_wan = '0;
  logic [4:0]        slot_ts = '0, slot_sub = '0;
  logic              awready, wready, bvalid, arready, rvalid, wan_tx_bit;
  logic [1:0]        bresp, rresp;
  logic [`NPORT-1:0] term_txd, term_rts, term_rxd, term_cts, cd, far_cd;
  logic [`NPORT-1:0] remote_rts = '0, rts_req = '0, tx_bit = '1;
  int                failures = 0, n_compared = 0;
  logic [1:0]        exp_b[$];
  logic [33:0]       exp_r[$];

  subrate_ds0_port_mux #(.CTS_D30_CYC(3), .CTS_D60_CYC(6), .CTS_D100_CYC(10)) dut_u (
    .sys_clk, .rst, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .term_txd, .term_rts, .term_rxd, .term_cts, .carrier_detect_lead(cd),
    .remote_rts, .far_cd, .wan_up, .slot_stb, .slot_wan, .slot_ts, .slot_sub,
    .wan_rx_bit, .wan_tx_bit);
  term_dte #(.N(`NPORT)) dte_u (.sys_clk, .rts_req, .tx_bit, .term_cts, .term_rts,
    .term_txd);

  // Clock
  initial forever #5 sys_clk = ~sys_clk;

  // Port configuration word
  function automatic logic [31:0] cw(input logic a, input logic [2:0] l,
      input logic [4:0] t, input logic [2:0] f, input logic [3:0] r,
      input logic [4:0] s, input logic [1:0] i);
    cw = {9'h000, i, s, r, f, t, l, a};
  endfunction

  // Register write, expected response noted first
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    exp_b.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge sys_clk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge sys_clk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    while (!bvalid) @(posedge sys_clk);
    bready <= 1'b0;
  endtask

  // Register read, expected answer noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    exp_r.push_back({r, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge sys_clk);
    rready <= 1'b0;
  endtask

  // One subrate bit position on link 0; port p below 0 skips the receive check
  task automatic slot(input logic [4:0] t, input logic [4:0] s, input logic rx,
      input logic tx_e, input int p);
    @(posedge sys_clk);
    slot_ts    <= t;
    slot_sub   <= s;
    wan_rx_bit <= rx;
    slot_stb   <= 1'b1;
    @(posedge sys_clk);
    slot_stb <= 1'b0;
    #1;
    `CHK(wan_tx_bit, tx_e, "transmit bit")
    if (p >= 0) `CHK(term_rxd[p], rx, "receive bit")
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic summarize();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compare every bus answer with the oldest note
  always @(posedge sys_clk) begin
    if (bvalid && bready) `CHK(bresp, exp_b.pop_front(), "write response")
    if (rvalid && rready) `CHK({rresp, rdata}, exp_r.pop_front(), "read answer")
  end

  // Watchdog against a hung handshake
  initial begin
    #300_000;
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end

  // Main sequence
  initial begin
    logic [31:0] w;
    logic        b;
    void'($urandom(32'h9DBB));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0001_0010, OK);
    rd(8'hD0, 32'h0, ER);
    $display("test reset done");
    wr(8'h00, cw(0, 0, 5'h00, FR_A, RT_0K3, 1, IF_ASYN), ER);
    wr(8'h00, cw(0, 0, 5'h19, FR_A, RT_0K3, 1, IF_ASYN), ER);
    wr(8'h00, cw(0, 0, 5'h18, FR_A, RT_0K3, 1, IF_ASYN), OK);
    wr(8'hC0, 32'h0000_0101, OK);
    wr(8'h00, cw(0, 0, 5'h10, FR_A, RT_0K3, 1, IF_ASYN), ER);
    wr(8'h00, cw(0, 0, 5'h1F, FR_A, RT_0K3, 5, IF_ASYN), OK);
    rd(8'h00, cw(0, 0, 5'h1F, FR_A, RT_0K3, 1, IF_ASYN), OK);
    $display("test slot range done");
    wr(8'h04, cw(1, 0, 2, FR_B5, RT_28K8, 1, IF_ASYN), OK);
    wr(8'h08, cw(1, 0, 2, FR_B5, RT_9K6, 3, IF_ASYN), ER);
    wr(8'h08, cw(1, 0, 2, FR_B5, RT_38K4, 3, IF_ASYN), ER);
    wr(8'h08, cw(1, 1, 2, FR_B5, RT_9K6, 4, IF_ASYN), ER);
    rd(8'hC8, 32'h2, OK);
    wr(8'h08, cw(1, 0, 2, FR_B5, RT_19K2, 4, IF_ASYN), OK);
    wr(8'h0C, cw(1, 0, 8, FR_X50, RT_19K2, 2, IF_ASYN), ER);
    wr(8'h0C, cw(1, 0, 8, FR_X50, RT_9K6, 6, IF_ASYN), ER);
    wr(8'h0C, cw(1, 0, 8, FR_X50, RT_9K6, 2, IF_ASYN), OK);
    wr(8'h10, cw(1, 0, 8, FR_X50, RT_4K8, 3, IF_ASYN), OK);
    $display("test subrate spans done");
    for (int p = 4; p < 8; p++)
      wr(8'(4 * p), cw(1, 0, 5'(p - 1), FR_B5, RT_38K4, 1, IF_SYNC), (p < 7) ? OK : ER);
    rd(8'hC4, 32'h0000_0480, OK);
    wr(8'h1C, cw(0, 0, 6, FR_B5, RT_1K2, 1, IF_SYNC), ER);
    wr(8'h1C, cw(0, 0, 6, FR_ADPCM, RT_14K4, 1, IF_SYNC) | 32'h1380_0000, OK);
    rd(8'h1C, cw(0, 0, 6, FR_ADPCM, RT_14K4, 0, IF_SYNC), OK);
    for (int p = 0; p < 6; p++) begin
      w = cw(0, 0, 9, FR_A, RT_2K4, 1, IF_ASYN) | {p[2:0], p[0], p[1:0], 23'h0};
      wr(8'h24, w, (p < 5) ? OK : ER);
      if (p < 5) rd(8'h24, w, OK);
    end
    wr(8'h5C, 32'h0000_0010, OK);
    wr(8'h1C, cw(1, 0, 6, FR_ADPCM, RT_14K4, 0, IF_ASYN), OK);
    rd(8'hCC, 32'h0000_0018, OK);
    $display("test bandwidth and format done");
    settle(3);
    `CHK(cd[1:0], 2'b10, "carrier detect by state")
    `CHK(term_cts[1:0], 2'b10, "clear to send by state")
    wan_up[0] <= 1'b0;
    settle(3);
    `CHK(cd[1], 1'b0, "carrier detect with link down")
    `CHK(term_cts[1], 1'b1, "clear to send with link down")
    wan_up[0] <= 1'b1;
    rts_req[3:0] <= 4'hB;
    tx_bit[3:0]  <= 4'h4;
    settle(8);
    for (int s = 1; s <= 5; s++) begin
      b = 1'($urandom_range(1, 0));
      slot(2, 5'(s), b, s > 3, (s > 3) ? 2 : 1);
    end
    for (int s = 1; s <= 20; s++) begin
      b = 1'($urandom_range(1, 0));
      slot(8, 5'(s), b, (s % 5) != 2, ((s % 5) == 2) ? 3 : -1);
    end
    ce <= 1'b0;
    slot(2, 1, 1'b0, 1'b1, -1);
    ce <= 1'b1;
    slot(5'h1F, 1, 1'b0, 1'b1, -1);
    `CHK(term_rxd[0], 1'b1, "standby receive idle")
    $display("test leads and stream done");
    wr(8'h20, cw(1, 0, 10, FR_A, RT_9K6, 1, IF_ASYN), OK);
    wr(8'h60, 32'h2, OK);
    rts_req[8] <= 1'b1;
    settle(4);
    `CHK(term_cts[8], 1'b0, "clear to send early")
    for (int k = 0; k < 12 && term_cts[8] !== 1'b1; k++) settle(1);
    `CHK(term_cts[8], 1'b1, "clear to send after delay")
    wr(8'h60, 32'h5, OK);
    settle(3);
    `CHK(far_cd[8], 1'b1, "far carrier request")
    wr(8'h60, 32'h9, OK);
    settle(3);
    `CHK(term_cts[8], 1'b0, "clear to send off")
    $display("test clear to send done");
    settle(4);
    summarize();
  end
endmodule
`default_nettype wire
